// [uppm_pkg.sv]
// Constants for the serial/parallel power and mode configuration bank
package uppm_pkg;
  // ==========================================================
  // Register indexes
  localparam logic [7:0] IDX_SER_PWR = 8'h02;
  localparam logic [7:0] IDX_RSV_3 = 8'h03;
  localparam logic [7:0] IDX_PP_MISC = 8'h04;
  localparam logic [7:0] IDX_RSV_5 = 8'h05;
  localparam logic [7:0] IDX_RSV_6 = 8'h06;
  localparam logic [7:0] IDX_AUTO_PWR = 8'h07;
  localparam logic [7:0] IDX_RSV_8 = 8'h08;
  localparam logic [7:0] IDX_TEST4 = 8'h09;
  localparam logic [7:0] IDX_FIFO_THR = 8'h0a;
  localparam logic [7:0] IDX_RSV_11 = 8'h0b;
  // ==========================================================
  // Power-on reset values
  localparam logic [7:0] RST_SER_PWR = 8'h08;
  localparam logic [7:0] RST_PP_MISC = 8'h00;
  localparam logic [7:0] RST_AUTO_PWR = 8'h00;
  localparam logic [7:0] RST_TEST4 = 8'h00;
  localparam logic [7:0] RST_FIFO_THR = 8'h00;
  localparam logic [7:0] RST_INDEX = 8'h00;
  // ==========================================================
  // Writable bit masks, everything else reads zero
  localparam logic [7:0] MSK_SER_PWR = 8'h08;
  localparam logic [7:0] MSK_PP_MISC = 8'h53;
  localparam logic [7:0] MSK_AUTO_PWR = 8'h50;
  localparam logic [7:0] MSK_TEST4 = 8'hff;
  localparam logic [7:0] MSK_FIFO_THR = 8'h0f;
  // Bits cleared by a hard reset
  localparam logic [7:0] HRST_CLR_SER_PWR = 8'h80;
  localparam logic [7:0] HRST_CLR_AUTO_PWR = 8'hf0;
  localparam logic [7:0] HRST_CLR_FIFO_THR = 8'hc0;
  // ==========================================================
  // Field positions
  localparam int SER_PWR_ON_BIT = 3;
  localparam int PP_EXT_LSB = 0;
  localparam int MIDI_EN_BIT = 4;
  localparam int EPP_TYPE_BIT = 6;
  localparam int AUTO_PP_BIT = 4;
  localparam int AUTO_UART_BIT = 6;
  localparam int THR_LSB = 0;
  // ==========================================================
  // Extended parallel field and ECP control mode codes
  localparam logic [1:0] EXT_SPP = 2'h0;
  localparam logic [1:0] EXT_EPP_SPP = 2'h1;
  localparam logic [1:0] EXT_ECP = 2'h2;
  localparam logic [1:0] EXT_ECP_EPP = 2'h3;
  localparam logic [2:0] ECR_SPP = 3'h0;
  localparam logic [2:0] ECR_EPP = 3'h4;
  // Lowest base address that still decodes
  localparam logic [15:0] DECODE_MIN_BASE = 16'h0100;
  // ==========================================================
  // MIDI bit timing, 16 samples per bit
  localparam int CLK_HZ = 200000000;
  localparam int MIDI_BAUD_HZ = 31250;
  localparam int MIDI_OVERSAMPLE = 16;
  localparam int MIDI_DIV = CLK_HZ / (MIDI_BAUD_HZ * MIDI_OVERSAMPLE);
  localparam logic [8:0] MIDI_DIV_LAST = 9'(MIDI_DIV - 1);
  // Effective parallel port operation, one-hot
  typedef enum logic [3:0] {
    PP_PRINTER = 4'h1,
    PP_SPP = 4'h2,
    PP_EPP = 4'h4,
    PP_ECP = 4'h8
  } uppm_pp_op_t;
endpackage

// [uppm_config_regs.sv]
// Serial/parallel power and mode configuration register bank
`timescale 1ns/1ps
// Overview of operation
// - Registers 02,04,07,09,0A answer only in config state with matching index.
// - Power-down never stops decoding; only a base below 100h does.
// - Powered-down device at a valid base stays in plug-and-play range checks.
// - Reserved indexes 03,05,06,08,0B and reserved bits read zero.
// - Extended field 00 SPP, 01 EPP+SPP, 10 ECP, 11 ECP+EPP; default 00.
// - ECP+EPP selection enters EPP when ECP control mode is 100.
// - ECP selections give standard parallel when ECP control mode is 000.
// - Misc bit 4 enables MIDI on the serial port; resets to zero.
// - MIDI enabled runs the serial port at 31.25 kilobaud within one percent.
// - Auto power bit 4 enables parallel auto power-down; default off.
// - Auto power bit 6 enables UART auto power-down; default off.
// - Hard reset clears auto power bits 7:4; power-on clears all.
// - Threshold bits 3:0 hold ECP FIFO threshold, 7:4 read zero, reset 00h.
// - Hard reset forces threshold bits 7:6 to 00, others kept.
// - Cleared lock bit blocks all config data reads and writes until reset; index writes still load.
// - Printer-mode bit high selects printer mode, low lets extended field govern.
module uppm_config_regs (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_b,
  // Hard reset pin, asynchronous to clk
  input wire logic hard_rst_b,
  // Configuration port, same clock
  input wire logic cfg_state,
  input wire logic index_wr,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [7:0] wdata,
  // Neighbouring register bits, same clock
  input wire logic config_access_lock_bit,
  input wire logic printer_mode,
  input wire logic [2:0] ecr_mode,
  // Programmed base addresses, same clock
  input wire logic [15:0] uart_base,
  input wire logic [15:0] pp_base,
  // Read port
  output logic [7:0] rdata,
  output logic rd_valid,
  output logic [7:0] config_index_register,
  // Serial port controls
  output logic uart_power_on,
  output logic midi_enable,
  output logic midi_tick,
  output logic uart_auto_pwr,
  output logic uart_decode_en,
  output logic uart_pnp_check,
  // Parallel port controls
  output logic [3:0] pp_op_mode,
  output logic epp_type_17,
  output logic pp_auto_pwr,
  output logic pp_decode_en,
  output logic pp_pnp_check,
  output logic [3:0] fifo_threshold,
  // Test bits
  output logic [7:0] test_bits
);

  // ==========================================================
  // Reset and hard reset synchronisers
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [1:0] hrst_sync_q;
  logic hard_rst;

  // Release reset through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Hard reset pin is a level, two flops before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrst_sync_q <= 2'h3;
    end else begin
      hrst_sync_q <= {hrst_sync_q[0], hard_rst_b};
    end
  end
  assign hard_rst = ~hrst_sync_q[1];

  // ==========================================================
  // Access qualification
  logic [7:0] index_q, index_d;
  logic access_ok;
  logic wr_en;
  logic rd_en;

  // Lock bit low shuts data reads and writes but not index loads, the owner re-arms it on reset
  assign access_ok = cfg_state & config_access_lock_bit;
  assign wr_en = access_ok & data_wr;
  assign rd_en = access_ok & data_rd;

  // Index register loads only in config state
  always_comb begin
    index_d = index_q;
    if (cfg_state && index_wr) begin
      index_d = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index_q <= uppm_pkg::RST_INDEX;
    end else begin
      index_q <= index_d;
    end
  end

  // Index match for one register; state and lock qualification comes from wr_en
  function automatic logic hit(input logic [7:0] idx, input logic [7:0] sel);
    hit = (idx == sel);
  endfunction

  // ==========================================================
  // Register storage
  logic [7:0] ser_pwr_q, ser_pwr_d;
  logic [7:0] pp_misc_q, pp_misc_d;
  logic [7:0] auto_pwr_q, auto_pwr_d;
  logic [7:0] test4_q, test4_d;
  logic [7:0] fifo_thr_q, fifo_thr_d;

  // Masked writes keep reserved bits zero; hard reset wins over a write
  always_comb begin
    ser_pwr_d = ser_pwr_q;
    pp_misc_d = pp_misc_q;
    auto_pwr_d = auto_pwr_q;
    test4_d = test4_q;
    fifo_thr_d = fifo_thr_q;
    if (wr_en && hit(index_q, uppm_pkg::IDX_SER_PWR)) begin
      ser_pwr_d = wdata & uppm_pkg::MSK_SER_PWR;
    end
    if (wr_en && hit(index_q, uppm_pkg::IDX_PP_MISC)) begin
      pp_misc_d = wdata & uppm_pkg::MSK_PP_MISC;
    end
    if (wr_en && hit(index_q, uppm_pkg::IDX_AUTO_PWR)) begin
      auto_pwr_d = wdata & uppm_pkg::MSK_AUTO_PWR;
    end
    if (wr_en && hit(index_q, uppm_pkg::IDX_TEST4)) begin
      test4_d = wdata & uppm_pkg::MSK_TEST4;
    end
    if (wr_en && hit(index_q, uppm_pkg::IDX_FIFO_THR)) begin
      fifo_thr_d = wdata & uppm_pkg::MSK_FIFO_THR;
    end
    // Hard reset touches only its own bits
    if (hard_rst) begin
      ser_pwr_d = ser_pwr_d & ~uppm_pkg::HRST_CLR_SER_PWR;
      auto_pwr_d = auto_pwr_d & ~uppm_pkg::HRST_CLR_AUTO_PWR;
      fifo_thr_d = fifo_thr_d & ~uppm_pkg::HRST_CLR_FIFO_THR;
    end
  end

  // Power-on defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_pwr_q <= uppm_pkg::RST_SER_PWR;
      pp_misc_q <= uppm_pkg::RST_PP_MISC;
      auto_pwr_q <= uppm_pkg::RST_AUTO_PWR;
      test4_q <= uppm_pkg::RST_TEST4;
      fifo_thr_q <= uppm_pkg::RST_FIFO_THR;
    end else begin
      ser_pwr_q <= ser_pwr_d;
      pp_misc_q <= pp_misc_d;
      auto_pwr_q <= auto_pwr_d;
      test4_q <= test4_d;
      fifo_thr_q <= fifo_thr_d;
    end
  end

  // ==========================================================
  // Read path
  logic [7:0] rdata_q, rdata_d;
  logic rd_valid_q, rd_valid_d;
  logic [7:0] read_mux;

  // Reserved and foreign indexes fall through to zero
  always_comb begin
    unique case (index_q)
      uppm_pkg::IDX_SER_PWR: read_mux = ser_pwr_q;
      uppm_pkg::IDX_PP_MISC: read_mux = pp_misc_q;
      uppm_pkg::IDX_AUTO_PWR: read_mux = auto_pwr_q;
      uppm_pkg::IDX_TEST4: read_mux = test4_q;
      uppm_pkg::IDX_FIFO_THR: read_mux = fifo_thr_q;
      default: read_mux = 8'h00;
    endcase
  end

  // Data stands until the next accepted read
  always_comb begin
    rdata_d = rdata_q;
    rd_valid_d = rd_en;
    if (rd_en) begin
      rdata_d = read_mux;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  // ==========================================================
  // Parallel port effective mode
  uppm_pkg::uppm_pp_op_t pp_op_q, pp_op_d;
  logic [1:0] ext_mode;

  assign ext_mode = pp_misc_q[uppm_pkg::PP_EXT_LSB +: 2];

  // Printer bit overrides; ECP control picks SPP in both ECP selections, EPP only in ECP+EPP
  always_comb begin
    pp_op_d = uppm_pkg::PP_SPP;
    if (printer_mode) begin
      pp_op_d = uppm_pkg::PP_PRINTER;
    end else begin
      unique case (ext_mode)
        uppm_pkg::EXT_SPP: pp_op_d = uppm_pkg::PP_SPP;
        uppm_pkg::EXT_EPP_SPP: pp_op_d = uppm_pkg::PP_EPP;
        uppm_pkg::EXT_ECP: begin
          if (ecr_mode == uppm_pkg::ECR_SPP) begin
            pp_op_d = uppm_pkg::PP_SPP;
          end else begin
            pp_op_d = uppm_pkg::PP_ECP;
          end
        end
        uppm_pkg::EXT_ECP_EPP: begin
          if (ecr_mode == uppm_pkg::ECR_SPP) begin
            pp_op_d = uppm_pkg::PP_SPP;
          end else if (ecr_mode == uppm_pkg::ECR_EPP) begin
            pp_op_d = uppm_pkg::PP_EPP;
          end else begin
            pp_op_d = uppm_pkg::PP_ECP;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pp_op_q <= uppm_pkg::PP_PRINTER;
    end else begin
      pp_op_q <= pp_op_d;
    end
  end

  // ==========================================================
  // Address decode and range check participation
  logic uart_dec_q, uart_dec_d;
  logic pp_dec_q, pp_dec_d;

  // Power-down bits are not looked at: only the base address gates decode
  always_comb begin
    uart_dec_d = (uart_base >= uppm_pkg::DECODE_MIN_BASE);
    pp_dec_d = (pp_base >= uppm_pkg::DECODE_MIN_BASE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uart_dec_q <= 1'b0;
      pp_dec_q <= 1'b0;
    end else begin
      uart_dec_q <= uart_dec_d;
      pp_dec_q <= pp_dec_d;
    end
  end

  // ==========================================================
  // MIDI sample tick, 16 per bit at 31.25 kbaud
  logic [8:0] midi_cnt_q, midi_cnt_d;
  logic midi_tick_q, midi_tick_d;
  logic midi_run;

  // Exact divide from 200 MHz, so no rate error at all
  assign midi_run = pp_misc_q[uppm_pkg::MIDI_EN_BIT] & ser_pwr_q[uppm_pkg::SER_PWR_ON_BIT];

  always_comb begin
    midi_cnt_d = 9'h000;
    midi_tick_d = 1'b0;
    if (midi_run) begin
      if (midi_cnt_q == uppm_pkg::MIDI_DIV_LAST) begin
        midi_tick_d = 1'b1;
      end else begin
        midi_cnt_d = midi_cnt_q + 9'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      midi_cnt_q <= 9'h000;
      midi_tick_q <= 1'b0;
    end else begin
      midi_cnt_q <= midi_cnt_d;
      midi_tick_q <= midi_tick_d;
    end
  end

  // ==========================================================
  // Outputs, all from flops
  assign rdata = rdata_q;
  assign rd_valid = rd_valid_q;
  assign config_index_register = index_q;
  assign uart_power_on = ser_pwr_q[uppm_pkg::SER_PWR_ON_BIT];
  assign midi_enable = pp_misc_q[uppm_pkg::MIDI_EN_BIT];
  assign midi_tick = midi_tick_q;
  assign uart_auto_pwr = auto_pwr_q[uppm_pkg::AUTO_UART_BIT];
  assign uart_decode_en = uart_dec_q;
  assign uart_pnp_check = uart_dec_q;
  assign pp_op_mode = pp_op_q;
  assign epp_type_17 = pp_misc_q[uppm_pkg::EPP_TYPE_BIT];
  assign pp_auto_pwr = auto_pwr_q[uppm_pkg::AUTO_PP_BIT];
  assign pp_decode_en = pp_dec_q;
  assign pp_pnp_check = pp_dec_q;
  assign fifo_threshold = fifo_thr_q[uppm_pkg::THR_LSB +: 4];
  // Test bits exported as stored; host is expected to leave them zero
  assign test_bits = test4_q;

endmodule

// [uppm_config_props.sv]
// Assertion checker for the configuration register bank
`timescale 1ns/1ps
module uppm_config_props (
  // Clock and resets
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hard_rst_b,
  // Host side
  input wire logic cfg_state,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [7:0] wdata,
  input wire logic config_access_lock_bit,
  input wire logic printer_mode,
  input wire logic [15:0] uart_base,
  input wire logic [7:0] config_index_register,
  // Outputs watched
  input wire logic [7:0] rdata,
  input wire logic rd_valid,
  input wire logic uart_power_on,
  input wire logic midi_enable,
  input wire logic uart_auto_pwr,
  input wire logic pp_auto_pwr,
  input wire logic [3:0] pp_op_mode,
  input wire logic [3:0] fifo_threshold,
  input wire logic uart_decode_en,
  input wire logic uart_pnp_check
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Accepted access: config state with the bank unlocked
  wire acc = cfg_state && config_access_lock_bit;
  wire [7:0] ix = config_index_register;
  a_read_gate_only: assert property (rd_valid == $past(acc && data_rd))
    else $error("read answer does not match accepted read");
  a_rsvd_read_zero: assert property (acc && data_rd &&
    ix inside {8'h03, 8'h05, 8'h06, 8'h08, 8'h0b} |=> rdata == 8'h00)
    else $error("reserved index read not zero");
  a_ser_pwr_write: assert property (acc && data_wr && ix == 8'h02
    |=> uart_power_on == $past(wdata[3])) else $error("serial power bit wrong");
  a_midi_bit_write: assert property (acc && data_wr && ix == 8'h04
    |=> midi_enable == $past(wdata[4])) else $error("midi enable wrong");
  // Hard reset wins over a write, so only writes well clear of it count
  a_auto_pwr_write: assert property (acc && data_wr && ix == 8'h07 &&
    hard_rst_b && $past(hard_rst_b, 2) |=> {uart_auto_pwr, pp_auto_pwr} ==
    $past({wdata[6], wdata[4]})) else $error("auto power bits wrong");
  a_hard_clr_auto: assert property ((!hard_rst_b) [*5] |-> !uart_auto_pwr && !pp_auto_pwr)
    else $error("hard reset left auto power set");
  a_thr_field_write: assert property (acc && data_wr && ix == 8'h0a
    |=> fifo_threshold == $past(wdata[3:0])) else $error("threshold wrong");
  a_printer_wins: assert property ($past(printer_mode) |-> pp_op_mode == 4'h1)
    else $error("printer mode not selected");
  a_decode_floor: assert property ({uart_decode_en, uart_pnp_check} ==
    {2{$past(uart_base) >= 16'h0100}}) else $error("decode floor wrong");
endmodule
bind uppm_config_regs uppm_config_props i_uppm_config_props (
  .clk(clk), .rst_b(rst_b), .hard_rst_b(hard_rst_b), .cfg_state(cfg_state),
  .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata),
  .config_access_lock_bit(config_access_lock_bit), .printer_mode(printer_mode),
  .uart_base(uart_base), .config_index_register(config_index_register),
  .rdata(rdata), .rd_valid(rd_valid), .uart_power_on(uart_power_on),
  .midi_enable(midi_enable), .uart_auto_pwr(uart_auto_pwr), .pp_auto_pwr(pp_auto_pwr),
  .pp_op_mode(pp_op_mode), .fifo_threshold(fifo_threshold),
  .uart_decode_en(uart_decode_en), .uart_pnp_check(uart_pnp_check));

// [uppm_host_model.sv]
// Host model driving the configuration port
`timescale 1ns/1ps
module uppm_host_model (
  // Clock
  input wire logic clk,
  // Port drive
  output logic cfg_state,
  output logic index_wr,
  output logic data_wr,
  output logic data_rd,
  output logic [7:0] wdata,
  // Read answer
  input wire logic [7:0] rdata,
  input wire logic rd_valid
);
  initial begin
    cfg_state = 1'b1;
    index_wr = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    wdata = 8'h00;
  end
  // Configuration state level, only ever changed at a clock edge
  task automatic state(input logic s);
    @(posedge clk);
    cfg_state <= s;
  endtask
  // Index first, then data; released data lines are scrambled
  task automatic put(input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    index_wr <= 1'b1;
    wdata <= i;
    @(posedge clk);
    index_wr <= 1'b0;
    data_wr <= 1'b1;
    wdata <= (i == 8'h09) ? 8'h00 : d;
    @(posedge clk);
    data_wr <= 1'b0;
    wdata <= ~wdata;
  endtask
  // Answer is taken just after the edge that lands it
  task automatic get(input logic [7:0] i, output logic [7:0] d, output logic v);
    @(posedge clk);
    index_wr <= 1'b1;
    wdata <= i;
    @(posedge clk);
    index_wr <= 1'b0;
    data_rd <= 1'b1;
    wdata <= ~i;
    @(posedge clk);
    data_rd <= 1'b0;
    #1;
    d = rdata;
    v = rd_valid;
  endtask
endmodule

// [uppm_config_regs_test.sv]
// Self-checking testbench for the configuration register bank
`timescale 1ns/1ps
module uppm_config_regs_test;
  logic clk, rst_b, hard_rst_b, config_access_lock_bit, printer_mode;
  logic cfg_state, index_wr, data_wr, data_rd, rd_valid, v;
  logic uart_power_on, midi_enable, midi_tick, uart_auto_pwr, uart_decode_en;
  logic uart_pnp_check, epp_type_17, pp_auto_pwr, pp_decode_en, pp_pnp_check;
  logic [2:0] ecr_mode;
  logic [3:0] pp_op_mode, fifo_threshold;
  logic [7:0] wdata, rdata, config_index_register, test_bits, d;
  logic [15:0] uart_base, pp_base;
  logic [7:0] msk [2:11] = '{8'h08, 8'h00, 8'h53, 8'h00, 8'h00, 8'h50, 8'h00, 8'h00,
    8'h0f, 8'h00};
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int gap;
  uppm_config_regs i_uppm_config_regs (
    .clk(clk), .rst_b(rst_b), .hard_rst_b(hard_rst_b), .cfg_state(cfg_state),
    .index_wr(index_wr), .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata),
    .config_access_lock_bit(config_access_lock_bit), .printer_mode(printer_mode),
    .ecr_mode(ecr_mode), .uart_base(uart_base), .pp_base(pp_base), .rdata(rdata),
    .rd_valid(rd_valid), .config_index_register(config_index_register),
    .uart_power_on(uart_power_on), .midi_enable(midi_enable), .midi_tick(midi_tick),
    .uart_auto_pwr(uart_auto_pwr), .uart_decode_en(uart_decode_en),
    .uart_pnp_check(uart_pnp_check), .pp_op_mode(pp_op_mode), .epp_type_17(epp_type_17),
    .pp_auto_pwr(pp_auto_pwr), .pp_decode_en(pp_decode_en), .pp_pnp_check(pp_pnp_check),
    .fifo_threshold(fifo_threshold), .test_bits(test_bits));
  uppm_host_model i_uppm_host_model (
    .clk(clk), .cfg_state(cfg_state), .index_wr(index_wr), .data_wr(data_wr),
    .data_rd(data_rd), .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid));
  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results;
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Parallel operation expected from selection e and control code index k
  function automatic logic [15:0] pm(input int e, input int k);
    if (e < 2) return (e == 0) ? 16'h0002 : 16'h0004;
    if (k == 0) return 16'h0002;
    return (e == 3 && k == 1) ? 16'h0004 : 16'h0008;
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    hard_rst_b = 1'b1;
    config_access_lock_bit = 1'b1;
    printer_mode = 1'b1;
    ecr_mode = 3'h0;
    uart_base = 16'h0000;
    pp_base = 16'h0000;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values, then all ones into every index but 09, which the host writes as 00; reserved bits stay zero
    for (int i = 2; i < 12; i++) begin
      i_uppm_host_model.get(8'(i), d, v);
      chk("reset value", (i == 2) ? 16'h0008 : 16'h0000, {8'h00, d});
      chk("read answer", 16'h0001, {15'h0000, v});
      chk("index", 16'(i), {8'h00, config_index_register});
      i_uppm_host_model.put(8'(i), 8'hff);
      i_uppm_host_model.get(8'(i), d, v);
      chk("written value", {8'h00, msk[i]}, {8'h00, d});
    end
    chk("serial bits", 16'h0007, {13'h0, uart_power_on, midi_enable, epp_type_17});
    chk("auto power", 16'h0003, {14'h0, uart_auto_pwr, pp_auto_pwr});
    chk("threshold", 16'h000f, {12'h000, fifo_threshold});
    chk("test bits", 16'h0000, {8'h00, test_bits});
    // Tick spacing at 16 samples per MIDI bit, silence once powered down
    @(posedge midi_tick);
    gap = 0;
    do begin
      @(posedge clk);
      #1;
      gap++;
    end while (midi_tick !== 1'b1 && gap < 1000);
    chk("midi tick gap", 16'(200000000 / (31250 * 16)), 16'(gap));
    i_uppm_host_model.put(8'h02, 8'h00);
    gap = 0;
    repeat (500) begin
      @(posedge clk);
      #1;
      gap += midi_tick;
    end
    chk("ticks while down", 16'h0000, 16'(gap));
    // Decode floor at 100h, serial port still powered down
    for (int b = 255; b < 257; b++) begin
      @(posedge clk);
      uart_base <= 16'(b);
      pp_base <= 16'(b);
      repeat (2) @(posedge clk);
      #1;
      chk("decode", (b > 255) ? 16'h000f : 16'h0000, {12'h000, uart_decode_en,
        uart_pnp_check, pp_decode_en, pp_pnp_check});
    end
    // Every extended selection against control codes 000, 100 and 011
    @(posedge clk);
    printer_mode <= 1'b0;
    for (int e = 0; e < 4; e++) begin
      i_uppm_host_model.put(8'h04, 8'(e));
      for (int k = 0; k < 3; k++) begin
        @(posedge clk);
        ecr_mode <= (k == 0) ? 3'h0 : (k == 1) ? 3'h4 : 3'h3;
        repeat (2) @(posedge clk);
        #1;
        chk("parallel mode", pm(e, k), {12'h000, pp_op_mode});
      end
    end
    @(posedge clk);
    printer_mode <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("printer mode", 16'h0001, {12'h000, pp_op_mode});
    // Hard reset clears only the upper auto power and threshold bits
    @(posedge clk);
    hard_rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    hard_rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    i_uppm_host_model.get(8'h07, d, v);
    chk("auto after hard", 16'h0000, {8'h00, d});
    i_uppm_host_model.get(8'h0a, d, v);
    chk("threshold after hard", 16'h000f, {8'h00, d});
    // Locked bank and config state left both refuse access
    @(posedge clk);
    config_access_lock_bit <= 1'b0;
    i_uppm_host_model.put(8'h0a, 8'h05);
    i_uppm_host_model.get(8'h0a, d, v);
    chk("locked answer", 16'h0000, {15'h0000, v});
    chk("locked write", 16'h000f, {12'h000, fifo_threshold});
    @(posedge clk);
    config_access_lock_bit <= 1'b1;
    i_uppm_host_model.state(1'b0);
    i_uppm_host_model.put(8'h0a, 8'h05);
    #1;
    chk("outside config write", 16'h000f, {12'h000, fifo_threshold});
    i_uppm_host_model.state(1'b1);
    i_uppm_host_model.get(8'h0a, d, v);
    chk("back in config", 16'h000f, {8'h00, d});
    results();
  end
endmodule
